// ### logic/pscg_clock_ctrl.v
// system clock controller: pll control, relock, sleep gating
// Functional notes
// - pll stays powered down after reset until software clears power-down.
// - pll runs 400 mhz, halved, then system divisor applied.
// - crystal change re-translates to pll settings, readable in readback register.
// - translation table keeps vco within one percent of target.
// - normal mode drives pll output; power-down does not.
// - relock only on crystal change or power-down to normal.
// - relock down-counter on main oscillator, loaded 0x1200, lock at expiry.
// - pll not selectable as system clock before counter expires.
// - enable and select at once: stay on oscillator until lock.
// - lock sets raw lock flag; interrupt raised when enabled.
// - run mode: cpu clocked, peripherals gated by run gates.
// - sleep: cpu stopped, same clock, sleep or run gates by auto-gating.
// - deep sleep: cpu stopped, deep or run gates by auto-gating.
// - deep sleep source main oscillator or configured internal oscillator.
// - pll running at deep entry: power it down, use divisor override.
// - on deep exit restore source and divisor before ungating clocks.
// - sleep on wfi only; deep needs deep enable; interrupt wakes.
// - extended select takes clock fields from extended register; here only while primary bit 31 is clear.
// - clearing power-down enables pll; crystal write loads translation.
// - effective divisor is field value plus one.
// - source 0 main, 1 internal, 2 internal/4, 3 slow internal.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "pscg_regs.vh"
module pscg_clock_ctrl (
    input wire ref_clk_in,
    input wire arst_n_in,
    input wire [7:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [31:0] rdata_out,
    input wire main_oscillator_clk_in,
    input wire wait_for_interrupt_instr_in,
    input wire deep_sleep_enable_in,
    input wire wake_irq_in,
    output reg pll_power_down_out,
    output reg pll_output_enable_out,
    output reg [13:0] pll_translation_out,
    output reg use_pll_out,
    output reg [1:0] oscillator_source_out,
    output reg [6:0] system_divisor_out,
    output reg main_osc_power_down_out,
    output reg cpu_clk_en_out,
    output reg [95:0] periph_clk_en_out,
    output reg pll_lock_irq_out,
    output reg [1:0] power_mode_out
);
    localparam MODE_RUN = 2'h0;
    localparam MODE_SLEEP = 2'h1;
    localparam MODE_DEEP = 2'h2;
    localparam MODE_WAKE = 2'h3;
    localparam PLL_VCO_DIV = `PSCG_PLL_MHZ / `PSCG_PLL_PREDIV;

    ////////////////////////////////////////////////////////////////////////
    reg [31:0] clock_config_primary;
    reg [31:0] clock_config_extended;
    reg [31:0] deep_sleep_clock_config;
    reg [31:0] run_gate_regs [0:2];
    reg [31:0] sleep_gate_regs [0:2];
    reg [31:0] deep_sleep_gate_regs [0:2];
    reg pll_lock_raw_flag;
    reg irq_mask;
    reg [1:0] mode;
    reg [6:0] saved_div;
    reg [1:0] saved_src;
    reg saved_pll;
    reg deep_pll_off;
    reg main_oscillator_s1, main_oscillator_s2, main_oscillator_s3;
    reg relock_trig;
    integer i;

    // pll translation: {divider-1 (5), multiplier (9)} per crystal code
    function [13:0] xlate;
        input [4:0] crystal_select;
        begin
            case (crystal_select)
                5'h04: xlate = {5'h00, 9'h07d};
                5'h05: xlate = {5'h00, 9'h06f};
                5'h06: xlate = {5'h00, 9'h064};
                5'h07: xlate = {5'h00, 9'h05f};
                5'h08: xlate = {5'h00, 9'h053};
                5'h09: xlate = {5'h00, 9'h055};
                5'h0a: xlate = {5'h00, 9'h051};
                5'h0b: xlate = {5'h00, 9'h064};
                5'h0c: xlate = {5'h00, 9'h04b};
                5'h0d: xlate = {5'h00, 9'h04c};
                5'h0e: xlate = {5'h00, 9'h040};
                5'h0f: xlate = {5'h00, 9'h03f};
                default: xlate = {5'h00, 9'h032};
            endcase
        end
    endfunction

    // active clock fields, primary or extended register
    wire ext = clock_config_primary[`PSCG_BIT_EXT_SEL] ? 1'b0 : clock_config_extended[`PSCG_BIT_EXT_SEL];
    wire [31:0] act = ext ? clock_config_extended : clock_config_primary;
    wire act_pll_power_down = act[`PSCG_BIT_PLL_POWER_DOWN];
    wire act_bypass = act[`PSCG_BIT_BYPASS];
    wire [1:0] act_src = act[`PSCG_BIT_OSC_LO +: 2];
    wire [6:0] act_div = ext ? {1'b0, act[`PSCG_BIT_DIV_LO +: 6]} + 7'h01
                             : {3'h0, act[`PSCG_BIT_DIV_LO +: 4]} + 7'h01;
    wire [4:0] crystal_select_now = clock_config_primary[`PSCG_BIT_CRYSTAL_SELECT_LO +: 5];
    wire autogate = clock_config_primary[`PSCG_BIT_AUTOGATE];
    wire pll_locked;
    wire lock_event;
    wire main_oscillator_tick = main_oscillator_s2 & ~main_oscillator_s3;

    ////////////////////////////////////////////////////////////////////////
    // register writes and relock triggers
    always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            clock_config_primary <= `PSCG_RST_CFG_PRI;
            clock_config_extended <= `PSCG_RST_CFG_EXT;
            deep_sleep_clock_config <= `PSCG_RST_DEEP_CFG;
            for (i = 0; i < 3; i = i + 1) begin
                run_gate_regs[i] <= (i == 0) ? `PSCG_RST_RUN_GATE0 : 32'h00000000;
                sleep_gate_regs[i] <= (i == 0) ? `PSCG_RST_RUN_GATE0 : 32'h00000000;
                deep_sleep_gate_regs[i] <= (i == 0) ? `PSCG_RST_RUN_GATE0 : 32'h00000000;
            end
            irq_mask <= 1'b0;
            relock_trig <= 1'b0;
            pll_translation_out <= 14'h0000;
        end else begin
            relock_trig <= 1'b0;
            pll_translation_out <= xlate(crystal_select_now);
            if (wr_in) begin
                case (addr_in)
                    `PSCG_OFF_CFG_PRI: begin
                        clock_config_primary <= wdata_in;
                        if (wdata_in[`PSCG_BIT_CRYSTAL_SELECT_LO +: 5] != crystal_select_now) relock_trig <= 1'b1;
                        if (!ext && act_pll_power_down && !wdata_in[`PSCG_BIT_PLL_POWER_DOWN]) relock_trig <= 1'b1;
                    end
                    `PSCG_OFF_CFG_EXT: begin
                        clock_config_extended <= wdata_in;
                        if (ext && act_pll_power_down && !wdata_in[`PSCG_BIT_PLL_POWER_DOWN]) relock_trig <= 1'b1;
                    end
                    `PSCG_OFF_DEEP_CFG: deep_sleep_clock_config <= wdata_in;
                    `PSCG_OFF_IRQ_MASK: irq_mask <= wdata_in[`PSCG_BIT_LOCK];
                    default: begin
                        for (i = 0; i < 3; i = i + 1) begin
                            if (addr_in == `PSCG_GATE_BASE + `PSCG_OFF_RUN_GATE + 8'h04 * i[7:0])
                                run_gate_regs[i] <= wdata_in;
                            if (addr_in == `PSCG_GATE_BASE + `PSCG_OFF_SLEEP_GATE + 8'h04 * i[7:0])
                                sleep_gate_regs[i] <= wdata_in;
                            if (addr_in == `PSCG_GATE_BASE + `PSCG_OFF_DEEP_GATE + 8'h04 * i[7:0])
                                deep_sleep_gate_regs[i] <= wdata_in;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, lock flag and interrupt
    always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_out <= 32'h00000000;
            pll_lock_raw_flag <= 1'b0;
            pll_lock_irq_out <= 1'b0;
        end else begin
            if (lock_event)
                pll_lock_raw_flag <= 1'b1;
            else if (relock_trig || (wr_in && addr_in == `PSCG_OFF_IRQ_CLR && wdata_in[`PSCG_BIT_LOCK]))
                pll_lock_raw_flag <= 1'b0;
            pll_lock_irq_out <= pll_lock_raw_flag & irq_mask;
            rdata_out <= 32'h00000000;
            if (rd_in) begin
                case (addr_in)
                    `PSCG_OFF_RAW_IRQ: rdata_out <= {25'h0, pll_lock_raw_flag, 6'h00};
                    `PSCG_OFF_IRQ_MASK: rdata_out <= {25'h0, irq_mask, 6'h00};
                    `PSCG_OFF_IRQ_CLR: rdata_out <= {25'h0, pll_lock_raw_flag & irq_mask, 6'h00};
                    `PSCG_OFF_CFG_PRI: rdata_out <= clock_config_primary;
                    `PSCG_OFF_PLL_XLATE: rdata_out <= {18'h0, pll_translation_out};
                    `PSCG_OFF_CFG_EXT: rdata_out <= clock_config_extended;
                    `PSCG_OFF_DEEP_CFG: rdata_out <= deep_sleep_clock_config;
                    default: begin
                        for (i = 0; i < 3; i = i + 1) begin
                            if (addr_in == `PSCG_GATE_BASE + `PSCG_OFF_RUN_GATE + 8'h04 * i[7:0])
                                rdata_out <= run_gate_regs[i];
                            if (addr_in == `PSCG_GATE_BASE + `PSCG_OFF_SLEEP_GATE + 8'h04 * i[7:0])
                                rdata_out <= sleep_gate_regs[i];
                            if (addr_in == `PSCG_GATE_BASE + `PSCG_OFF_DEEP_GATE + 8'h04 * i[7:0])
                                rdata_out <= deep_sleep_gate_regs[i];
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // main oscillator sampling for the relock counter
    always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            main_oscillator_s1 <= 1'b0;
            main_oscillator_s2 <= 1'b0;
            main_oscillator_s3 <= 1'b0;
        end else begin
            main_oscillator_s1 <= main_oscillator_clk_in;
            main_oscillator_s2 <= main_oscillator_s1;
            main_oscillator_s3 <= main_oscillator_s2;
        end
    end

    pscg_relock u_relock (
        .ref_clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .main_oscillator_tick_in(main_oscillator_tick),
        .trigger_in(relock_trig),
        .locked_out(pll_locked),
        .lock_event_out(lock_event)
    );

    ////////////////////////////////////////////////////////////////////////
    // power mode machine and clock outputs
    always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mode <= MODE_RUN;
            saved_div <= 7'h10;
            saved_src <= 2'h0;
            saved_pll <= 1'b0;
            deep_pll_off <= 1'b0;
            pll_power_down_out <= 1'b1;
            pll_output_enable_out <= 1'b0;
            use_pll_out <= 1'b0;
            oscillator_source_out <= 2'h0;
            system_divisor_out <= 7'h10;
            main_osc_power_down_out <= 1'b0;
            cpu_clk_en_out <= 1'b1;
            periph_clk_en_out <= 96'h0;
            power_mode_out <= MODE_RUN;
        end else begin
            case (mode)
                MODE_RUN: begin
                    cpu_clk_en_out <= 1'b1;
                    periph_clk_en_out <= {run_gate_regs[2], run_gate_regs[1], run_gate_regs[0]};
                    pll_power_down_out <= act_pll_power_down;
                    pll_output_enable_out <= ~act_pll_power_down;
                    use_pll_out <= ~act_bypass & ~act_pll_power_down & pll_locked;
                    oscillator_source_out <= act_src;
                    system_divisor_out <= act[`PSCG_BIT_USE_DIVIDER] ? act_div : 7'h01;
                    main_osc_power_down_out <= 1'b0;
                    if (wait_for_interrupt_instr_in && !wake_irq_in) begin
                        cpu_clk_en_out <= 1'b0;
                        saved_div <= act[`PSCG_BIT_USE_DIVIDER] ? act_div : 7'h01;
                        saved_src <= act_src;
                        saved_pll <= ~act_bypass & ~act_pll_power_down & pll_locked;
                        mode <= deep_sleep_enable_in ? MODE_DEEP : MODE_SLEEP;
                        power_mode_out <= deep_sleep_enable_in ? MODE_DEEP : MODE_SLEEP;
                        deep_pll_off <= deep_sleep_enable_in & ~act_pll_power_down;
                        if (deep_sleep_enable_in) begin
                            pll_power_down_out <= 1'b1;
                            pll_output_enable_out <= 1'b0;
                            use_pll_out <= 1'b0;
                        end
                    end
                end
                MODE_SLEEP: begin
                    cpu_clk_en_out <= 1'b0;
                    periph_clk_en_out <= autogate ? {sleep_gate_regs[2], sleep_gate_regs[1], sleep_gate_regs[0]}
                                                  : {run_gate_regs[2], run_gate_regs[1], run_gate_regs[0]};
                    if (wake_irq_in) begin
                        mode <= MODE_WAKE;
                        power_mode_out <= MODE_WAKE;
                    end
                end
                MODE_DEEP: begin
                    cpu_clk_en_out <= 1'b0;
                    periph_clk_en_out <= autogate
                        ? {deep_sleep_gate_regs[2], deep_sleep_gate_regs[1], deep_sleep_gate_regs[0]}
                        : {run_gate_regs[2], run_gate_regs[1], run_gate_regs[0]};
                    oscillator_source_out <= deep_sleep_clock_config[`PSCG_BIT_DS_OSC_LO +: 2];
                    main_osc_power_down_out <= (deep_sleep_clock_config[`PSCG_BIT_DS_OSC_LO +: 2] != 2'h0);
                    if (deep_pll_off) begin
                        pll_power_down_out <= 1'b1;
                        pll_output_enable_out <= 1'b0;
                        use_pll_out <= 1'b0;
                        system_divisor_out <= ext
                            ? {1'b0, deep_sleep_clock_config[`PSCG_BIT_DS_DIV_LO +: 6]} + 7'h01
                            : {3'h0, deep_sleep_clock_config[`PSCG_BIT_DS_DIV_LO +: 4]} + 7'h01;
                    end
                    if (wake_irq_in) begin
                        mode <= MODE_WAKE;
                        power_mode_out <= MODE_WAKE;
                        oscillator_source_out <= saved_src;
                        system_divisor_out <= saved_div;
                        main_osc_power_down_out <= 1'b0;
                        pll_power_down_out <= act_pll_power_down;
                        pll_output_enable_out <= ~act_pll_power_down;
                        use_pll_out <= saved_pll & pll_locked;
                    end
                end
                MODE_WAKE: begin
                    // clocks stay gated this cycle while source is restored
                    oscillator_source_out <= saved_src;
                    system_divisor_out <= saved_div;
                    main_osc_power_down_out <= 1'b0;
                    pll_power_down_out <= act_pll_power_down;
                    pll_output_enable_out <= ~act_pll_power_down;
                    use_pll_out <= saved_pll & pll_locked;
                    deep_pll_off <= 1'b0;
                    cpu_clk_en_out <= 1'b1;
                    periph_clk_en_out <= {run_gate_regs[2], run_gate_regs[1], run_gate_regs[0]};
                    mode <= MODE_RUN;
                    power_mode_out <= MODE_RUN;
                end
                default: begin
                    mode <= MODE_RUN;
                    power_mode_out <= MODE_RUN;
                end
            endcase
        end
    end
endmodule // pscg_clock_ctrl
`default_nettype wire

// ### inc/pscg_regs.vh
// register offsets, field positions, reset values and timing counts for the clock controller
`ifndef PSCG_REGS_VH
`define PSCG_REGS_VH
`define PSCG_ADDR_W 8
`define PSCG_OFF_RAW_IRQ 8'h50
`define PSCG_OFF_IRQ_MASK 8'h54
`define PSCG_OFF_IRQ_CLR 8'h58
`define PSCG_OFF_CFG_PRI 8'h60
`define PSCG_OFF_PLL_XLATE 8'h64
`define PSCG_OFF_CFG_EXT 8'h70
`define PSCG_OFF_RUN_GATE 8'h00
`define PSCG_OFF_SLEEP_GATE 8'h10
`define PSCG_OFF_DEEP_GATE 8'h20
`define PSCG_OFF_DEEP_CFG 8'h44
`define PSCG_GATE_BASE 8'hf0
`define PSCG_GATE_PAGE 8'h00
`define PSCG_RST_CFG_PRI 32'h07803ad1
`define PSCG_RST_CFG_EXT 32'h07802810
`define PSCG_RST_RUN_GATE0 32'h00000040
`define PSCG_RST_DEEP_CFG 32'h07800000
`define PSCG_BIT_LOCK 6
`define PSCG_BIT_OSC_LO 4
`define PSCG_BIT_CRYSTAL_SELECT_LO 6
`define PSCG_BIT_BYPASS 11
`define PSCG_BIT_PLL_POWER_DOWN 13
`define PSCG_BIT_USE_DIVIDER 22
`define PSCG_BIT_DIV_LO 23
`define PSCG_BIT_AUTOGATE 27
`define PSCG_BIT_EXT_SEL 31
`define PSCG_BIT_DS_OSC_LO 4
`define PSCG_BIT_DS_DIV_LO 23
`define PSCG_RELOCK_LOAD 16'h1200
`define PSCG_PLL_MHZ 400
`define PSCG_PLL_PREDIV 2
`endif

// ### logic/pscg_relock.v
// relock down-counter running on the main oscillator samples
`timescale 1ns/10ps
`default_nettype none
`include "pscg_regs.vh"
module pscg_relock (
    input wire ref_clk_in,
    input wire arst_n_in,
    input wire main_oscillator_tick_in,
    input wire trigger_in,
    output reg locked_out,
    output reg lock_event_out
);
    reg [15:0] count;
    always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count <= 16'h0000;
            locked_out <= 1'b0;
            lock_event_out <= 1'b0;
        end else begin
            lock_event_out <= 1'b0;
            if (trigger_in) begin
                count <= `PSCG_RELOCK_LOAD;
                locked_out <= 1'b0;
            end else if (main_oscillator_tick_in && count != 16'h0000) begin
                if (count <= 16'h0001) begin
                    count <= 16'h0000;
                    locked_out <= 1'b1;
                    lock_event_out <= 1'b1;
                end else begin
                    count <= count - 16'h0001;
                end
            end
        end
    end
endmodule // pscg_relock
`default_nettype wire

// ### dv/pscg_clock_ctrl_chk.sv
// port assertions for the system clock controller
`timescale 1ns/10ps
`default_nettype none
module pscg_clock_ctrl_chk (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic wait_for_interrupt_instr_in,
    input wire logic deep_sleep_enable_in,
    input wire logic wake_irq_in,
    input wire logic pll_power_down_out,
    input wire logic pll_output_enable_out,
    input wire logic use_pll_out,
    input wire logic cpu_clk_en_out,
    input wire logic [1:0] power_mode_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    ////////////////////////////////
    pll_out_gate_a: assert property (pll_output_enable_out |-> !pll_power_down_out)
        else $error("pll output driven while powered down");
    pll_select_a: assert property (use_pll_out |-> pll_output_enable_out)
        else $error("pll selected while not running");
    read_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data outside read cycle");
    sleep_entry_a: assert property (power_mode_out == 2'h0 && wait_for_interrupt_instr_in && !wake_irq_in
        |=> power_mode_out == ($past(deep_sleep_enable_in) ? 2'h2 : 2'h1) && !cpu_clk_en_out)
        else $error("sleep not entered on request");
    no_sleep_a: assert property (power_mode_out == 2'h0 && !wait_for_interrupt_instr_in
        |=> power_mode_out == 2'h0)
        else $error("sleep entered without request");
    run_cpu_a: assert property (power_mode_out == 2'h0 |-> cpu_clk_en_out)
        else $error("cpu unclocked in run");
    sleep_cpu_a: assert property (power_mode_out inside {2'h1, 2'h2} |-> !cpu_clk_en_out)
        else $error("cpu clocked while asleep");
    wake_seq_a: assert property (power_mode_out inside {2'h1, 2'h2} && wake_irq_in
        |=> power_mode_out == 2'h3 ##1 power_mode_out == 2'h0 && cpu_clk_en_out)
        else $error("wake sequence wrong");
    wake_hold_a: assert property (power_mode_out == 2'h3 |-> !cpu_clk_en_out)
        else $error("cpu clocked before restore");
    deep_pll_a: assert property (power_mode_out == 2'h2 |-> pll_power_down_out && !use_pll_out)
        else $error("pll running in deep sleep");
endmodule // pscg_clock_ctrl_chk
bind pscg_clock_ctrl pscg_clock_ctrl_chk pscg_clock_ctrl_chk_i (.ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .wait_for_interrupt_instr_in(wait_for_interrupt_instr_in), .deep_sleep_enable_in(deep_sleep_enable_in),
    .wake_irq_in(wake_irq_in), .pll_power_down_out(pll_power_down_out),
    .pll_output_enable_out(pll_output_enable_out), .use_pll_out(use_pll_out),
    .cpu_clk_en_out(cpu_clk_en_out), .power_mode_out(power_mode_out));
`default_nettype wire

// ### dv/pscg_core_model.sv
// processor core and crystal model on the far side
`timescale 1ns/10ps
`default_nettype none
module pscg_core_model (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic sleep_cmd_in,
    input wire logic deep_cmd_in,
    input wire logic wake_cmd_in,
    input wire logic [1:0] power_mode_in,
    output logic xclk_out,
    output logic slp_req_out,
    output logic deep_en_out,
    output logic wake_out
);
    initial begin
        xclk_out = 1'b0;
        forever #31 xclk_out = ~xclk_out;
    end
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            slp_req_out <= 1'b0;
            deep_en_out <= 1'b0;
            wake_out <= 1'b0;
        end else begin
            deep_en_out <= deep_cmd_in;
            slp_req_out <= sleep_cmd_in && power_mode_in == 2'h0;
            if (wake_cmd_in) begin
                wake_out <= 1'b1;
            end else if (power_mode_in == 2'h0) begin
                wake_out <= 1'b0;
            end
        end
    end
endmodule // pscg_core_model
`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the system clock controller
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk, rst_n, wr, rd, rd_d, slp, dse, wake, pd, oe, up, mpd, cpu, irq, xclk, sl_cmd, dp_cmd, wk_cmd;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, seed;
    logic [31:0] g [0:8];
    logic [31:0] q [$];
    logic [13:0] xl;
    logic [1:0] osc, mode;
    logic [6:0] div;
    logic [95:0] per;
    int fails, tests_run, ticks, n, i;
    pscg_clock_ctrl pscg_clock_ctrl_i (.ref_clk_in(clk), .arst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .main_oscillator_clk_in(xclk), .wait_for_interrupt_instr_in(slp),
        .deep_sleep_enable_in(dse), .wake_irq_in(wake), .pll_power_down_out(pd), .pll_output_enable_out(oe),
        .pll_translation_out(xl), .use_pll_out(up), .oscillator_source_out(osc), .system_divisor_out(div),
        .main_osc_power_down_out(mpd), .cpu_clk_en_out(cpu), .periph_clk_en_out(per),
        .pll_lock_irq_out(irq), .power_mode_out(mode));
    pscg_core_model pscg_core_model_i (.clk_in(clk), .arst_n_in(rst_n), .sleep_cmd_in(sl_cmd),
        .deep_cmd_in(dp_cmd), .wake_cmd_in(wk_cmd), .power_mode_in(mode), .xclk_out(xclk),
        .slp_req_out(slp), .deep_en_out(dse), .wake_out(wake));
    ////////////////////////////////
    task stop_test();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task chk(input logic [95:0] s, input logic [95:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task settle(input int c);
        repeat (c) @(negedge clk);
    endtask
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function logic [31:0] cfg(input logic [1:0] o, input logic [4:0] x, input logic b, input logic p,
        input logic u, input logic [3:0] d);
        return {4'h0, 1'b1, d, u, 8'h0, p, 1'b0, b, x, o, 4'h0};
    endfunction
    task relock(input logic [31:0] w);
        wr_reg(8'h60, w);
        ticks = 0;
        settle(3);
        chk(up, 1'b0);
        chk(pd, 1'b0);
        chk(oe, 1'b1);
        for (n = 0; n < 20000 && up !== 1'b1; n++) @(negedge clk);
        chk(up, 1'b1);
        chk(ticks >= 32'h1200 && ticks <= 32'h1206, 1'b1);
    endtask
    task nap(input logic d);
        @(posedge clk);
        dp_cmd <= d;
        @(posedge clk);
        sl_cmd <= 1'b1;
        @(posedge clk);
        sl_cmd <= 1'b0;
        settle(3);
        chk(mode, d ? 2'h2 : 2'h1);
        chk(cpu, 1'b0);
        chk(up, !d);
        chk(per, d ? {g[8], g[7], g[6]} : {g[5], g[4], g[3]});
        if (d) begin
            chk({pd, mpd, osc, div}, {1'b1, 1'b1, 2'h1, 7'h8});
        end
    endtask
    task wake_up();
        @(posedge clk);
        wk_cmd <= 1'b1;
        dp_cmd <= 1'b0;
        @(posedge clk);
        wk_cmd <= 1'b0;
        for (n = 0; n < 20 && mode !== 2'h3; n++) @(negedge clk);
        chk({mode, osc, div}, {2'h3, 2'h0, 7'h5});
        settle(1);
        chk({mode, cpu, per}, {2'h0, 1'b1, g[2], g[1], g[0]});
    endtask
    ////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge xclk) ticks++;
    always @(posedge clk) begin
        if (rd_d) chk(rdata, q.pop_front());
        rd_d <= rd;
    end
    initial begin
        #2000000;
        fails++;
        stop_test();
    end
    initial begin
        {rst_n, wr, rd, rd_d, sl_cmd, dp_cmd, wk_cmd} = 7'h0;
        addr = 8'h0;
        wdata = 32'h0;
        seed = 32'h846c;
        {fails, tests_run, ticks} = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        settle(2);
        chk({pd, cpu, per}, {1'b1, 1'b1, 96'h40});
        rd_reg(8'h60, 32'h07803ad1);
        rd_reg(8'h70, 32'h07802810);
        rd_reg(8'h44, 32'h07800000);
        rd_reg(8'h80, 32'h0);
        wr_reg(8'h50, 32'hffffffff);
        rd_reg(8'h50, 32'h0);
        for (i = 0; i < 9; i++) begin
            g[i] = rnd();
            wr_reg(8'(240 + 16 * (i / 3) + 4 * (i % 3)), g[i]);
            rd_reg(8'(240 + 16 * (i / 3) + 4 * (i % 3)), g[i]);
        end
        settle(2);
        chk(per, {g[2], g[1], g[0]});
        for (i = 0; i < 4; i++) begin
            wr_reg(8'h60, cfg(2'(i), 5'h10, 1'b1, 1'b1, 1'b1, 4'(i + 2)));
            settle(2);
            chk({osc, div, pd}, {2'(i), 7'(i + 3), 1'b1});
        end
        wr_reg(8'h70, 32'h9fc02810);
        settle(2);
        chk(div, 7'h40);
        wr_reg(8'h70, 32'h07802810);
        wr_reg(8'h60, cfg(2'h0, 5'h10, 1'b1, 1'b1, 1'b0, 4'h9));
        settle(2);
        chk(div, 7'h1);
        relock(cfg(2'h0, 5'h10, 1'b0, 1'b0, 1'b1, 4'h4));
        rd_reg(8'h50, 32'h40);
        wr_reg(8'h54, 32'h40);
        settle(2);
        chk(irq, 1'b1);
        wr_reg(8'h60, cfg(2'h0, 5'h10, 1'b0, 1'b0, 1'b1, 4'h4));
        settle(50);
        chk({up, irq}, 2'h3);
        wr_reg(8'h58, 32'h40);
        settle(2);
        chk(irq, 1'b0);
        rd_reg(8'h50, 32'h0);
        wr_reg(8'h60, cfg(2'h0, 5'h11, 1'b0, 1'b0, 1'b1, 4'h4));
        settle(400);
        relock(cfg(2'h0, 5'h12, 1'b0, 1'b0, 1'b1, 4'h4));
        settle(2);
        chk(irq, 1'b1);
        wr_reg(8'h44, 32'h03800010);
        nap(1'b0);
        wake_up();
        nap(1'b1);
        wake_up();
        repeat (3) @(posedge clk);
        stop_test();
    end
endmodule // tb
`default_nettype wire
